// ---- core/qpsc_core.sv ----
`timescale 1ns/10ps
// Contract
// - sample serial_in on SCK rising edge
// - drive serial_out only for read data
// - wiper value decoded one-hot of 64
// - four wipers: write, load, step
// - wipers recalled from stored zero
// - four 6-bit stored registers per pot
// - stored write lasts at most 10ms
// - nv save starts on select rise
// - pending flag during nv write, readable
// - first byte carries checked type code
// - address bits must match straps
// - instruction byte: opcode, register, pot
// - transfers end after instruction byte
// - global transfer acts on all pots
// - wiper moves after settle; nv transfer
// - data commands use three-byte sequence
// - step pulses move wiper up/down
// - stepping accepts unbounded pulses
// - opcode encodings as listed
// - read data shifted on SCK fall
// - write guard low blocks nv writes
// - pause keeps sequence state
module qpsc_core
#(
   parameter int unsigned NV_CYCLES = qpsc_pkg::NV_WRITE_CYCLES
)
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic sck,
   input wire logic serial_in,
   input wire logic select_low,
   input wire logic serial_pause_n,
   input wire logic write_guard_n,
   input wire logic [1:0] address_strap_pins,
   output logic serial_out,
   output logic serial_out_oe,
   output logic nv_write_pending_flag,
   output logic [4*qpsc_pkg::NUM_TAPS-1:0] tap_enable
);
   import qpsc_pkg::*;

   function automatic logic [NUM_TAPS-1:0] onehot(input logic [5:0] v);
      onehot = {{(NUM_TAPS-1){1'b0}}, 1'b1} << v;
   endfunction : onehot

   qpsc_link_if link();
   qpsc_pin_sync u_sync
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .sck(sck),
      .serial_in(serial_in),
      .select_low(select_low),
      .serial_pause_n(serial_pause_n),
      .write_guard_n(write_guard_n),
      .link(link)
   );

   qpsc_state_t state_q, state_d;
   logic [2:0] bit_q;
   logic [7:0] sh_q;
   logic [3:0] op_q;
   logic [1:0] rsel_q;
   logic [1:0] psel_q;
   logic [7:0] tx_q;
   logic tx_en_q;
   logic [5:0] wiper_q [NUM_POTS];
   logic [5:0] shown_q [NUM_POTS];
   logic [5:0] stored_q [NUM_POTS][NUM_STORED];
   logic [NUM_STORED-1:0] recall_done_q;
   logic recalled_q;
   logic nv_arm_q;
   logic nv_glob_q;
   logic nv_from_wiper_q;
   logic [5:0] nv_data_q;
   logic [31:0] nv_cnt_q;
   logic nv_busy_q;
   logic [$clog2(SETTLE_CYCLES+1)-1:0] settle_q;
   // straps are pins too, so they get two flops like the link
   logic [1:0] strap_s1_q;
   logic [1:0] strap_s2_q;

   // the link only advances while selected and not paused
   wire active = link.sel_active & ~link.pause;
   wire rise = active & link.sck_rise;
   wire fall = active & link.sck_fall;
   wire [7:0] byte_in = {sh_q[6:0], link.din};
   wire byte_done = rise & (bit_q == 3'd7);
   wire id_ok = (byte_in[7:4] == ID_TYPE_CODE) &
      (byte_in[1:0] == strap_s2_q);
   wire [3:0] op_in = byte_in[7:4];
   wire is_xfr = (op_in == OP_XFR_TO_WIPER) | (op_in == OP_XFR_TO_STORED) |
      (op_in == OP_GXFR_TO_WIPER) | (op_in == OP_GXFR_TO_STORED);
   wire is_data = (op_in == OP_RD_WIPER) | (op_in == OP_WR_WIPER) |
      (op_in == OP_RD_STORED) | (op_in == OP_WR_STORED) |
      (op_in == OP_STATUS);
   wire [1:0] r_in = byte_in[3:2];
   wire [1:0] p_in = byte_in[1:0];
   wire instr_done = byte_done & (state_q == QPSC_INSTR);
   wire data_done = byte_done & (state_q == QPSC_DATA);
   wire step_evt = rise & (state_q == QPSC_STEP);
   wire nv_start = link.sel_rise & nv_arm_q & ~nv_busy_q &
      link.guard_ok;

   always_comb
   begin
      state_d = state_q;
      if (!link.sel_active)
         state_d = QPSC_ID;
      else if (byte_done)
      begin
         case (state_q)
            QPSC_ID: state_d = id_ok ? QPSC_INSTR : QPSC_IGNORE;
            QPSC_INSTR: state_d = is_data ? QPSC_DATA :
               (op_in == OP_STEP) ? QPSC_STEP : QPSC_IGNORE;
            QPSC_DATA: state_d = QPSC_IGNORE;
            QPSC_STEP: state_d = QPSC_STEP;
            QPSC_IGNORE: state_d = QPSC_IGNORE;
            default: state_d = QPSC_IGNORE;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= QPSC_ID;
         bit_q <= 3'd0;
         sh_q <= 8'h00;
         op_q <= 4'h0;
         rsel_q <= 2'b00;
         psel_q <= 2'b00;
         strap_s1_q <= 2'h0;
         strap_s2_q <= 2'h0;
      end
      else
      begin
         state_q <= state_d;
         strap_s1_q <= address_strap_pins;
         strap_s2_q <= strap_s1_q;
         if (!link.sel_active)
            bit_q <= 3'd0;
         else if (rise)
         begin
            bit_q <= bit_q + 3'd1;
            sh_q <= byte_in;
         end
         if (instr_done)
         begin
            op_q <= op_in;
            rsel_q <= r_in;
            psel_q <= p_in;
         end
      end
   end

   // read byte loaded at instruction end, shifted on falling edges
   wire [5:0] rd_val = (op_in == OP_RD_WIPER) ? wiper_q[p_in] :
      (op_in == OP_RD_STORED) ? stored_q[p_in][r_in] :
      {5'b00000, nv_busy_q};
   wire is_read = (op_in == OP_RD_WIPER) | (op_in == OP_RD_STORED) |
      (op_in == OP_STATUS);
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         tx_q <= 8'h00;
         tx_en_q <= 1'b0;
         serial_out <= 1'b0;
         serial_out_oe <= 1'b0;
      end
      else
      begin
         if (instr_done & is_read)
         begin
            tx_q <= {2'b00, rd_val};
            tx_en_q <= 1'b1;
         end
         else if (data_done | ~link.sel_active)
            tx_en_q <= 1'b0;
         if (fall & tx_en_q & (state_q == QPSC_DATA))
         begin
            serial_out <= tx_q[7];
            serial_out_oe <= 1'b1;
            tx_q <= {tx_q[6:0], 1'b0};
         end
         else if (~tx_en_q | ~link.sel_active)
            serial_out_oe <= 1'b0;
      end
   end

   // power-up recall: wipers load from stored zero once out of reset
   wire do_recall = ~recalled_q;
   genvar gp;
   generate
      for (gp = 0; gp < NUM_POTS; gp++)
      begin : g_pot
         wire hit = (psel_q == 2'(gp));
         always_ff @(posedge ref_clk or posedge rst)
         begin
            if (rst)
               wiper_q[gp] <= TAP_MIN;
            else if (do_recall)
               wiper_q[gp] <= stored_q[gp][0];
            else if (data_done & hit & (op_q == OP_WR_WIPER))
               wiper_q[gp] <= byte_in[5:0];
            else if (instr_done & (op_in == OP_XFR_TO_WIPER) &
               (p_in == 2'(gp)))
               wiper_q[gp] <= stored_q[gp][r_in];
            else if (instr_done & (op_in == OP_GXFR_TO_WIPER))
               wiper_q[gp] <= stored_q[gp][r_in];
            else if (step_evt & hit)
            begin
               if (link.din && wiper_q[gp] != TAP_MAX)
                  wiper_q[gp] <= wiper_q[gp] + 6'd1;
               else if (!link.din && wiper_q[gp] != TAP_MIN)
                  wiper_q[gp] <= wiper_q[gp] - 6'd1;
            end
         end
         // switch position follows the counter after the settle delay
         always_ff @(posedge ref_clk or posedge rst)
         begin
            if (rst)
               shown_q[gp] <= TAP_MIN;
            else if (settle_q == '0)
               shown_q[gp] <= wiper_q[gp];
         end
         always_ff @(posedge ref_clk or posedge rst)
         begin
            if (rst)
               tap_enable[gp*NUM_TAPS +: NUM_TAPS] <= {{(NUM_TAPS-1){1'b0}},
                  1'b1};
            else
               tap_enable[gp*NUM_TAPS +: NUM_TAPS] <= onehot(shown_q[gp]);
         end
      end
   endgenerate

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         recalled_q <= 1'b0;
         settle_q <= '0;
      end
      else
      begin
         recalled_q <= 1'b1;
         if (data_done | instr_done | step_evt)
            settle_q <= SETTLE_CYCLES[$bits(settle_q)-1:0];
         else if (settle_q != '0)
            settle_q <= settle_q - 1'b1;
      end
   end

   // nv write: armed by a complete command, started at deselect
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         nv_arm_q <= 1'b0;
         nv_glob_q <= 1'b0;
         nv_from_wiper_q <= 1'b0;
         nv_data_q <= 6'h00;
         nv_busy_q <= 1'b0;
         nv_cnt_q <= 32'd0;
         nv_write_pending_flag <= 1'b0;
      end
      else
      begin
         if (link.sel_rise)
            nv_arm_q <= 1'b0;
         else if (data_done & (op_q == OP_WR_STORED) & ~nv_busy_q)
         begin
            nv_arm_q <= 1'b1;
            nv_from_wiper_q <= 1'b0;
            nv_glob_q <= 1'b0;
            nv_data_q <= byte_in[5:0];
         end
         else if (instr_done & ~nv_busy_q & ((op_in == OP_XFR_TO_STORED) |
            (op_in == OP_GXFR_TO_STORED)))
         begin
            nv_arm_q <= 1'b1;
            nv_from_wiper_q <= 1'b1;
            nv_glob_q <= (op_in == OP_GXFR_TO_STORED);
         end
         else if (byte_done & (state_q != QPSC_ID))
            nv_arm_q <= 1'b0; // overrun bytes cancel the save
         if (nv_start)
         begin
            nv_busy_q <= 1'b1;
            nv_cnt_q <= NV_CYCLES - 1;
         end
         else if (nv_busy_q)
         begin
            if (nv_cnt_q == 32'd0)
               nv_busy_q <= 1'b0;
            else
               nv_cnt_q <= nv_cnt_q - 32'd1;
         end
         nv_write_pending_flag <= nv_busy_q | nv_start;
      end
   end

   // commit takes effect at save start, which keeps the window simple
   genvar sp, sr;
   generate
      for (sp = 0; sp < NUM_POTS; sp++)
      begin : g_sp
         for (sr = 0; sr < NUM_STORED; sr++)
         begin : g_sr
            wire sel = (rsel_q == 2'(sr)) &
               (nv_glob_q | (psel_q == 2'(sp)));
            always_ff @(posedge ref_clk or posedge rst)
            begin
               if (rst)
                  stored_q[sp][sr] <= STORED_RESET;
               else if (nv_start & sel)
                  stored_q[sp][sr] <= nv_from_wiper_q ? wiper_q[sp] :
                     nv_data_q;
            end
         end
      end
   endgenerate

   a_nv_flag_len: assert property (@(posedge ref_clk) disable iff (rst)
      nv_start |=> nv_busy_q [*8])
      else $error("pending flag dropped early");
   a_guard_blocks: assert property (@(posedge ref_clk) disable iff (rst)
      (link.sel_rise & ~link.guard_ok) |=> !$rose(nv_busy_q))
      else $error("nv write under guard");
   a_step_sat: assert property (@(posedge ref_clk) disable iff (rst)
      (step_evt & link.din & wiper_q[psel_q] == TAP_MAX) |=>
      wiper_q[psel_q] == TAP_MAX)
      else $error("wiper wrapped");
   a_oe_idle: assert property (@(posedge ref_clk) disable iff (rst)
      !link.sel_active |=> !serial_out_oe)
      else $error("serial_out driven while deselected");
   a_onehot_tap: assert property (@(posedge ref_clk) disable iff (rst)
      $onehot(tap_enable[NUM_TAPS-1:0]))
      else $error("tap decode not one-hot");
   a_pause_hold: assert property (@(posedge ref_clk) disable iff (rst)
      (link.pause & link.sel_active) |=> $stable(bit_q))
      else $error("sequence moved during pause");
   a_bad_id: assert property (@(posedge ref_clk) disable iff (rst)
      (byte_done & state_q == QPSC_ID & !id_ok) |=>
      state_q == QPSC_IGNORE)
      else $error("mismatched id accepted");
   a_start_sel: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(nv_busy_q) |-> $past(link.sel_rise))
      else $error("nv save without deselect");
   c_read: cover property (@(posedge ref_clk) serial_out_oe);
   c_step: cover property (@(posedge ref_clk) step_evt);
   c_nv: cover property (@(posedge ref_clk) nv_start);
endmodule : qpsc_core

// ---- core/qpsc_pin_sync.sv ----
`timescale 1ns/10ps
module qpsc_pin_sync
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic sck,
   input wire logic serial_in,
   input wire logic select_low,
   input wire logic serial_pause_n,
   input wire logic write_guard_n,
   qpsc_link_if.front link
);
   // two flops per pin; only stage two feeds logic
   logic [4:0] s1_q;
   logic [4:0] s2_q;
   logic sck_prev_q;
   logic sel_prev_q;
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         s1_q <= 5'h1C;
         s2_q <= 5'h1C;
         sck_prev_q <= 1'b0;
         sel_prev_q <= 1'b1;
      end
      else
      begin
         s1_q <= {write_guard_n, serial_pause_n, select_low, serial_in, sck};
         s2_q <= s1_q;
         sck_prev_q <= s2_q[0];
         sel_prev_q <= s2_q[2];
      end
   end
   assign link.sck_rise = s2_q[0] & ~sck_prev_q;
   assign link.sck_fall = ~s2_q[0] & sck_prev_q;
   assign link.din = s2_q[1];
   assign link.sel_active = ~s2_q[2];
   assign link.sel_rise = s2_q[2] & ~sel_prev_q;
   assign link.pause = ~s2_q[3];
   assign link.guard_ok = s2_q[4];
endmodule : qpsc_pin_sync

// ---- include/qpsc_link_if.sv ----
`timescale 1ns/10ps
interface qpsc_link_if;
   logic sck_rise;
   logic sck_fall;
   logic sel_active;
   logic sel_rise;
   logic din;
   logic pause;
   logic guard_ok;
   modport front (output sck_rise, sck_fall, sel_active, sel_rise, din,
      pause, guard_ok);
   modport core (input sck_rise, sck_fall, sel_active, sel_rise, din,
      pause, guard_ok);
endinterface : qpsc_link_if

// ---- include/qpsc_pkg.sv ----
package qpsc_pkg;
   localparam int unsigned NUM_POTS = 4;
   localparam int unsigned NUM_STORED = 4;
   localparam int unsigned TAP_W = 6;
   localparam int unsigned NUM_TAPS = 64;
   // identification byte layout
   // type code value is arbitrary; any fixed nibble serves
   localparam logic [3:0] ID_TYPE_CODE = 4'h6;
   localparam int unsigned ID_TYPE_LSB = 4;
   localparam int unsigned ID_ADDR_LSB = 0;
   // instruction byte layout
   localparam int unsigned OP_LSB = 4;
   localparam int unsigned REG_LSB = 2;
   localparam int unsigned POT_LSB = 0;
   // opcodes
   localparam logic [3:0] OP_RD_WIPER = 4'h9;
   localparam logic [3:0] OP_WR_WIPER = 4'hA;
   localparam logic [3:0] OP_RD_STORED = 4'hB;
   localparam logic [3:0] OP_WR_STORED = 4'hC;
   localparam logic [3:0] OP_XFR_TO_WIPER = 4'hD;
   localparam logic [3:0] OP_XFR_TO_STORED = 4'hE;
   localparam logic [3:0] OP_GXFR_TO_WIPER = 4'h1;
   localparam logic [3:0] OP_GXFR_TO_STORED = 4'h8;
   localparam logic [3:0] OP_STEP = 4'h2;
   localparam logic [3:0] OP_STATUS = 4'h5;
   localparam logic [TAP_W-1:0] TAP_MAX = 6'h3F;
   localparam logic [TAP_W-1:0] TAP_MIN = 6'h00;
   localparam logic [TAP_W-1:0] STORED_RESET = 6'h00;
   // timing
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned NV_WRITE_MS = 10;
   localparam int unsigned NV_WRITE_CYCLES = NV_WRITE_MS * 1000 * CLK_MHZ;
   localparam int unsigned SETTLE_NS = 10;
   localparam int unsigned SETTLE_CYCLES = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   typedef enum logic [2:0]
   {
      QPSC_ID = 3'b000,
      QPSC_INSTR = 3'b001,
      QPSC_DATA = 3'b011,
      QPSC_STEP = 3'b010,
      QPSC_IGNORE = 3'b110
   } qpsc_state_t;
endpackage : qpsc_pkg

// ---- verification/qpsc_host_model.sv ----
`timescale 1ns/10ps
module qpsc_host_model
(
   input wire logic ref_clk,
   input wire logic so_line,
   output logic sck,
   output logic serial_in,
   output logic select_low,
   output logic serial_pause_n,
   output logic write_guard_n
);
   initial
   begin
      sck = 1'b0;
      serial_in = 1'b0;
      select_low = 1'b1;
      serial_pause_n = 1'b1;
      write_guard_n = 1'b1;
   end
   // half of an 80 ns link period, changes land on the falling edge
   task automatic half();
      repeat (8) @(negedge ref_clk);
   endtask : half
   task automatic bit_x(input logic b, output logic r);
      serial_in = b;
      half();
      sck = 1'b1;
      r = so_line;
      half();
      sck = 1'b0;
   endtask : bit_x
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         bit_x(tx[i], rx[i]);
      end
   endtask : xfer
   task automatic open_seq(input logic [7:0] id, input logic [7:0] ins);
      logic [7:0] junk;
      select_low = 1'b0;
      half();
      xfer(id, junk);
      xfer(ins, junk);
   endtask : open_seq
   // the data line is flipped on release so a stale level never matches
   task automatic close_seq(input logic g);
      half();
      write_guard_n = g;
      half();
      select_low = 1'b1;
      serial_in = ~serial_in;
      half();
      write_guard_n = 1'b1;
   endtask : close_seq
   task automatic frame(input logic [3:0] typ, input logic [1:0] addr,
      input logic [7:0] ins, input logic [7:0] dat, input int n,
      input logic g, output logic [7:0] rx);
      rx = 8'h00;
      open_seq({typ, 2'b00, addr}, ins);
      if (n > 2)
      begin
         xfer(dat, rx);
      end
      close_seq(g);
   endtask : frame
endmodule : qpsc_host_model

// ---- verification/quad_pot_serial_command_tb.sv ----
`timescale 1ns/10ps
module quad_pot_serial_command_tb;
   import qpsc_pkg::*;
   localparam int unsigned NV = 1000;
   logic ref_clk, rst, sck, serial_in, select_low;
   logic serial_pause_n, write_guard_n;
   logic [1:0] strap;
   logic serial_out, serial_out_oe, nv_write_pending_flag;
   logic [4*NUM_TAPS-1:0] tap_enable;
   logic [7:0] rx;
   logic r;
   int errors, cmp_count, cycles;
   // a released line shows the inverse so a stale bit never matches
   wire so_line = serial_out_oe ? serial_out : ~serial_out;
   qpsc_core #(.NV_CYCLES(NV)) i_qpsc_core (.ref_clk(ref_clk), .rst(rst),
      .sck(sck), .serial_in(serial_in), .select_low(select_low),
      .serial_pause_n(serial_pause_n), .write_guard_n(write_guard_n),
      .address_strap_pins(strap), .serial_out(serial_out),
      .serial_out_oe(serial_out_oe),
      .nv_write_pending_flag(nv_write_pending_flag),
      .tap_enable(tap_enable));
   qpsc_host_model i_qpsc_host_model (.ref_clk(ref_clk), .so_line(so_line),
      .sck(sck), .serial_in(serial_in), .select_low(select_low),
      .serial_pause_n(serial_pause_n), .write_guard_n(write_guard_n));
   task automatic give_verdict();
      if (errors == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : give_verdict
   task automatic cmp(input string what, input logic [63:0] exp,
      input logic [63:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   function automatic logic [63:0] lane(input int p);
      return tap_enable[p*64 +: 64];
   endfunction : lane
   task automatic cmd(input logic [3:0] op, input logic [1:0] rs,
      input logic [1:0] ps, input logic [7:0] d, input int n);
      i_qpsc_host_model.frame(ID_TYPE_CODE, 2'b10, {op, rs, ps}, d, n,
         1'b1, rx);
      repeat (4) @(negedge ref_clk);
   endtask : cmd
   task automatic nv_wait();
      int k;
      k = 0;
      while (nv_write_pending_flag !== 1'b0 && k < 2 * NV)
      begin
         @(negedge ref_clk);
         k++;
      end
      cmp("nv flag idle", 64'h0, {63'h0, nv_write_pending_flag});
   endtask : nv_wait
   task automatic t_reset();
      for (int p = 0; p < 4; p++)
         cmp("tap after reset", 64'h1, lane(p));
      cmp("oe idle", 64'h0, {63'h0, serial_out_oe});
   endtask : t_reset
   task automatic t_wiper();
      cmd(OP_WR_WIPER, 2'd0, 2'd2, 8'h2A, 3);
      cmp("tap pot2", 64'h1 << 42, lane(2));
      cmd(OP_RD_WIPER, 2'd0, 2'd2, 8'h00, 3);
      cmp("read wiper", 64'h2A, {56'h0, rx});
      cmp("oe released", 64'h0, {63'h0, serial_out_oe});
   endtask : t_wiper
   task automatic t_stored();
      cmd(OP_WR_STORED, 2'd3, 2'd1, 8'h15, 3);
      cmp("nv flag busy", 64'h1, {63'h0, nv_write_pending_flag});
      cmd(OP_STATUS, 2'd0, 2'd1, 8'h00, 3);
      cmp("status", 64'h1, {56'h0, rx});
      nv_wait();
      cmd(OP_RD_STORED, 2'd3, 2'd1, 8'h00, 3);
      cmp("read stored", 64'h15, {56'h0, rx});
   endtask : t_stored
   task automatic t_guard();
      i_qpsc_host_model.frame(ID_TYPE_CODE, 2'b10, {OP_WR_STORED, 4'hD},
         8'h07, 3, 1'b0, rx);
      repeat (4) @(negedge ref_clk);
      cmp("guarded flag", 64'h0, {63'h0, nv_write_pending_flag});
      cmd(OP_RD_STORED, 2'd3, 2'd1, 8'h00, 3);
      cmp("guarded stored", 64'h15, {56'h0, rx});
   endtask : t_guard
   task automatic t_xfer();
      cmd(OP_XFR_TO_WIPER, 2'd3, 2'd1, 8'h00, 2);
      cmp("xfer to wiper", 64'h1 << 21, lane(1));
      cmd(OP_GXFR_TO_STORED, 2'd1, 2'd0, 8'h00, 2);
      nv_wait();
      cmd(OP_WR_WIPER, 2'd0, 2'd2, 8'h00, 3);
      cmd(OP_WR_WIPER, 2'd0, 2'd1, 8'h00, 3);
      cmd(OP_GXFR_TO_WIPER, 2'd1, 2'd0, 8'h00, 2);
      cmp("global pot1", 64'h1 << 21, lane(1));
      cmp("global pot2", 64'h1 << 42, lane(2));
      cmp("global pot0", 64'h1, lane(0));
      cmd(OP_XFR_TO_STORED, 2'd0, 2'd2, 8'h00, 2);
      nv_wait();
      cmd(OP_RD_STORED, 2'd0, 2'd2, 8'h00, 3);
      cmp("xfer to stored", 64'h2A, {56'h0, rx});
   endtask : t_xfer
   task automatic t_ident();
      i_qpsc_host_model.frame(ID_TYPE_CODE, 2'b01, {OP_WR_WIPER, 4'h0},
         8'h11, 3, 1'b1, rx);
      repeat (4) @(negedge ref_clk);
      cmp("wrong address", 64'h1, lane(0));
      i_qpsc_host_model.frame(~ID_TYPE_CODE, 2'b10, {OP_WR_WIPER, 4'h0},
         8'h11, 3, 1'b1, rx);
      repeat (4) @(negedge ref_clk);
      cmp("wrong type", 64'h1, lane(0));
   endtask : t_ident
   task automatic t_step();
      i_qpsc_host_model.open_seq({ID_TYPE_CODE, 4'h2}, {OP_STEP, 4'h3});
      for (int i = 0; i < 8; i++)
         i_qpsc_host_model.bit_x(i >= 3, r);
      i_qpsc_host_model.close_seq(1'b1);
      cmp("step floor", 64'h1 << 5, lane(3));
      cmd(OP_WR_WIPER, 2'd0, 2'd3, 8'h3E, 3);
      i_qpsc_host_model.open_seq({ID_TYPE_CODE, 4'h2}, {OP_STEP, 4'h3});
      for (int i = 0; i < 3; i++)
         i_qpsc_host_model.bit_x(1'b1, r);
      i_qpsc_host_model.close_seq(1'b1);
      cmp("step ceiling", 64'h1 << 63, lane(3));
   endtask : t_step
   task automatic t_pause();
      i_qpsc_host_model.open_seq({ID_TYPE_CODE, 4'h2}, {OP_WR_WIPER, 4'h0});
      i_qpsc_host_model.serial_pause_n = 1'b0;
      for (int i = 0; i < 8; i++)
         i_qpsc_host_model.bit_x(1'b1, r);
      i_qpsc_host_model.serial_pause_n = 1'b1;
      i_qpsc_host_model.xfer(8'h09, rx);
      i_qpsc_host_model.close_seq(1'b1);
      repeat (4) @(negedge ref_clk);
      cmp("paused write", 64'h1 << 9, lane(0));
   endtask : t_pause
   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   // ceiling well above the roughly 10.5k cycles the sequence needs
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         errors++;
         give_verdict();
      end
   end
   initial
   begin
      rst = 1'b1;
      strap = 2'b10;
      errors = 0;
      cmp_count = 0;
      cycles = 0;
      repeat (12) @(negedge ref_clk);
      rst = 1'b0;
      repeat (8) @(negedge ref_clk);
      t_reset();
      t_wiper();
      t_stored();
      t_guard();
      t_xfer();
      t_ident();
      t_step();
      t_pause();
      give_verdict();
   end
endmodule : quad_pot_serial_command_tb
